// ### pwmc_pkg.sv
// package: register map, field layout and timing constants of the pwm channel
package pwmc_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_DUTY     = 12'h008;
  localparam logic [11:0] OFF_PERIOD   = 12'h00c;
  localparam logic [11:0] OFF_BUFFER   = 12'h010;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h014;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h018;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h01c;
  localparam logic [11:0] OFF_COUNT    = 12'h020;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_BUF_EN  = 1;
  localparam int CTRL_PIN_EN  = 2;
  localparam int IRQ_DUTY     = 0;
  localparam int IRQ_PERIOD   = 1;
  localparam int CNT_W        = 16;
  localparam int PRESC_W      = 2;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0]   CNT_ZERO     = 16'h0000;
  localparam logic [CNT_W-1:0]   CNT_ONE      = 16'h0001;
  localparam logic [CNT_W-1:0]   COMPARE_RST  = 16'hffff;
  localparam logic [2:0]         CTRL_RST     = 3'h0;
  localparam logic [PRESC_W-1:0] PRESC_DIV    = 2'h3;
  localparam logic [31:0]        UNMAPPED_RD  = 32'h00000000;

  typedef struct packed {
    logic run;
    logic buf_en;
    logic pin_en;
  } pwmc_ctrl_t;

  typedef struct packed {
    logic period;
    logic duty;
  } pwmc_evt_t;

endpackage : pwmc_pkg

// ### pwmc_tick.sv
// count-clock enable divider
module pwmc_tick (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  output logic      tick
);
  logic [pwmc_pkg::PRESC_W-1:0] cnt;
  logic [pwmc_pkg::PRESC_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (!enable) begin
      next_cnt = '0;
    end else if (cnt == pwmc_pkg::PRESC_DIV) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // one pclk pulse per divide span
  assign tick = enable && (cnt == pwmc_pkg::PRESC_DIV);
endmodule // pwmc_tick

// ### pwmc_irq_bit.sv
// one sticky interrupt status bit
module pwmc_irq_bit (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);
  logic next_flag;

  // set wins over a clear in the same cycle
  always_comb begin
    next_flag = flag;
    if (set) begin
      next_flag = 1'b1;
    end else if (clr) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule // pwmc_irq_bit

// ### pwmc_top.sv
// single channel pwm timer with duty buffer and apb registers
//
// Summary of operation
// - counter clears on period compare match
// - period match alone drives output low
// - duty match alone drives output high
// - buffered mode copies buffer into duty on duty match
// - simultaneous matches hold output, 100% if it was high
// - duty above period never matches, 0%
// - colliding buffer write: old contents transfer
// - output low until pin mode enables it
// - interrupts on every period and duty match
// - raised duty may match twice, no change
// - unbuffered duty=period at period irq gives 0%
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
module pwmc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pwm_out,
  output logic             irq
);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic wr_acc;
  logic rd_acc;
  logic wr_ctrl;
  logic wr_duty;
  logic wr_period;
  logic wr_buffer;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic hit;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    wr_ctrl    = 1'b0;
    wr_duty    = 1'b0;
    wr_period  = 1'b0;
    wr_buffer  = 1'b0;
    wr_irq_en  = 1'b0;
    wr_irq_clr = 1'b0;
    hit        = 1'b1;
    if (paddr == pwmc_pkg::OFF_CTRL) begin
      wr_ctrl = wr_acc;
    end else if (paddr == pwmc_pkg::OFF_DUTY) begin
      wr_duty = wr_acc;
    end else if (paddr == pwmc_pkg::OFF_PERIOD) begin
      wr_period = wr_acc;
    end else if (paddr == pwmc_pkg::OFF_BUFFER) begin
      wr_buffer = wr_acc;
    end else if (paddr == pwmc_pkg::OFF_IRQ_EN) begin
      wr_irq_en = wr_acc;
    end else if (paddr == pwmc_pkg::OFF_IRQ_CLR) begin
      wr_irq_clr = wr_acc;
    end else if (paddr == pwmc_pkg::OFF_STATUS ||
                 paddr == pwmc_pkg::OFF_IRQ_STAT ||
                 paddr == pwmc_pkg::OFF_COUNT) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // unmapped access errors but has no effect
  assign pslverr = psel && penable && !hit;

  // ------------------------------------------------------------
  // channel state
  // ------------------------------------------------------------
  pwmc_pkg::pwmc_ctrl_t      ctrl;
  pwmc_pkg::pwmc_ctrl_t      next_ctrl;
  logic [pwmc_pkg::CNT_W-1:0] count;
  logic [pwmc_pkg::CNT_W-1:0] next_count;
  logic [pwmc_pkg::CNT_W-1:0] duty_compare_reg;
  logic [pwmc_pkg::CNT_W-1:0] next_duty;
  logic [pwmc_pkg::CNT_W-1:0] period_compare_reg;
  logic [pwmc_pkg::CNT_W-1:0] next_period;
  logic [pwmc_pkg::CNT_W-1:0] duty_buffer_reg;
  logic [pwmc_pkg::CNT_W-1:0] next_buffer;
  logic                       level;
  logic                       next_level;
  logic [1:0]                 irq_en;
  logic [1:0]                 next_irq_en;
  logic                       tick;
  pwmc_pkg::pwmc_evt_t        evt;
  pwmc_pkg::pwmc_evt_t        flags;

  // count rate is pclk divided down; slower rates are left to software
  pwmc_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (ctrl.run),
    .tick    (tick)
  );

  // compares are evaluated only on count ticks
  assign evt.duty   = tick && (count == duty_compare_reg);
  assign evt.period = tick && (count == period_compare_reg);

  always_comb begin
    next_ctrl   = ctrl;
    next_count  = count;
    next_duty   = duty_compare_reg;
    next_period = period_compare_reg;
    next_buffer = duty_buffer_reg;
    next_level  = level;
    next_irq_en = irq_en;

    if (wr_ctrl) begin
      next_ctrl.run    = pwdata[pwmc_pkg::CTRL_RUN];
      next_ctrl.buf_en = pwdata[pwmc_pkg::CTRL_BUF_EN];
      next_ctrl.pin_en = pwdata[pwmc_pkg::CTRL_PIN_EN];
    end
    if (wr_period) begin
      next_period = pwdata[pwmc_pkg::CNT_W-1:0];
    end
    if (wr_irq_en) begin
      next_irq_en = {pwdata[pwmc_pkg::IRQ_PERIOD],
                     pwdata[pwmc_pkg::IRQ_DUTY]};
    end

    // counter
    if (evt.period) begin
      next_count = pwmc_pkg::CNT_ZERO;
    end else if (tick) begin
      next_count = count + pwmc_pkg::CNT_ONE;
    end

    // output level: a lone match acts, a pair leaves it alone
    if (evt.period && !evt.duty) begin
      next_level = 1'b0;
    end else if (evt.duty && !evt.period) begin
      next_level = 1'b1;
    end else begin
      next_level = level;
    end

    // software write to duty first; a transfer in the same cycle wins
    if (wr_duty) begin
      next_duty = pwdata[pwmc_pkg::CNT_W-1:0];
    end
    if (wr_buffer) begin
      next_buffer = pwdata[pwmc_pkg::CNT_W-1:0];
    end
    // transfer uses the buffer as it stood before this cycle's write
    if (ctrl.buf_en && evt.duty) begin
      next_duty = duty_buffer_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl               <= pwmc_pkg::CTRL_RST;
      count              <= pwmc_pkg::CNT_ZERO;
      duty_compare_reg   <= pwmc_pkg::COMPARE_RST;
      period_compare_reg <= pwmc_pkg::COMPARE_RST;
      duty_buffer_reg    <= pwmc_pkg::COMPARE_RST;
      level              <= 1'b0;
      irq_en             <= 2'h0;
    end else begin
      ctrl               <= next_ctrl;
      count              <= next_count;
      duty_compare_reg   <= next_duty;
      period_compare_reg <= next_period;
      duty_buffer_reg    <= next_buffer;
      level              <= next_level;
      irq_en             <= next_irq_en;
    end
  end

  // ------------------------------------------------------------
  // pin and interrupts
  // ------------------------------------------------------------
  // pin stays at initial low until pin mode hands it to the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= ctrl.pin_en && level;
    end
  end

  pwmc_irq_bit u_irq_duty (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (evt.duty),
    .clr     (wr_irq_clr && pwdata[pwmc_pkg::IRQ_DUTY]),
    .flag    (flags.duty)
  );

  pwmc_irq_bit u_irq_period (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (evt.period),
    .clr     (wr_irq_clr && pwdata[pwmc_pkg::IRQ_PERIOD]),
    .flag    (flags.period)
  );

  assign irq = |({flags.period, flags.duty} & irq_en);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    prdata = pwmc_pkg::UNMAPPED_RD;
    if (!rd_acc) begin
      prdata = pwmc_pkg::UNMAPPED_RD;
    end else if (paddr == pwmc_pkg::OFF_CTRL) begin
      prdata[2:0] = {ctrl.pin_en, ctrl.buf_en, ctrl.run};
    end else if (paddr == pwmc_pkg::OFF_STATUS) begin
      prdata[0] = level;
    end else if (paddr == pwmc_pkg::OFF_DUTY) begin
      prdata[pwmc_pkg::CNT_W-1:0] = duty_compare_reg;
    end else if (paddr == pwmc_pkg::OFF_PERIOD) begin
      prdata[pwmc_pkg::CNT_W-1:0] = period_compare_reg;
    end else if (paddr == pwmc_pkg::OFF_BUFFER) begin
      prdata[pwmc_pkg::CNT_W-1:0] = duty_buffer_reg;
    end else if (paddr == pwmc_pkg::OFF_IRQ_STAT) begin
      prdata[1:0] = {flags.period, flags.duty};
    end else if (paddr == pwmc_pkg::OFF_IRQ_EN) begin
      prdata[1:0] = irq_en;
    end else if (paddr == pwmc_pkg::OFF_COUNT) begin
      prdata[pwmc_pkg::CNT_W-1:0] = count;
    end
  end
endmodule // pwmc_top

// ### pwmc_checker.sv
// port assertions for the pwm channel
module pwmc_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pwm_out,
  input wire logic        irq
);
  // ----------------------------------------
  // apb and pin relations
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable;
  AST_PREADY: assert property (pready) else $error("pready low");
  AST_UNMAPPED_ERR: assert property (acc && paddr > 12'h020 |-> pslverr)
    else $error("no error on unmapped");
  AST_MAPPED_OK: assert property (acc && paddr <= pwmc_pkg::OFF_COUNT &&
    paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped");
  AST_IDLE_RD: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read");
  AST_UNMAPPED_RD: assert property (acc && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_STAT: assert property (acc && !pwrite && irq &&
    paddr == pwmc_pkg::OFF_IRQ_STAT |-> prdata[1:0] != 2'h0)
    else $error("irq without flag");
  AST_IRQ_OFF: assert property (acc && pwrite && pwdata[1:0] == 2'h0 &&
    paddr == pwmc_pkg::OFF_IRQ_EN |=> !irq) else $error("masked irq");
  AST_RESET_LOW: assert property ($rose(presetn) |-> !pwm_out ##1 !pwm_out)
    else $error("pin high after reset");
endmodule // pwmc_checker

// ### pwmc_load.sv
// load model: counts cycles with the pwm pin high
module pwmc_load (
  input  wire logic        pclk,
  input  wire logic        pwm_in,
  input  wire logic        clr,
  output logic      [15:0] high_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // integrates the pin like an rc filter, phase is ignored
  always_ff @(posedge pclk) begin
    if (clr) begin
      high_cnt <= 16'h0000;
    end else if (pwm_in) begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end
endmodule // pwmc_load

// ### pwmc_top_bench.sv
// self-checking bench for the pwm channel
module pwmc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        clr = 1'b0;
  logic [31:0] prdata, rd;
  logic [15:0] high_cnt;
  logic        pready, pslverr, pwm_out, irq, err;
  int          mismatches = 0;
  int          num_checks = 0;
  always #10 pclk = ~pclk;
  pwmc_top i_pwmc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out(pwm_out), .irq(irq));
  pwmc_load i_pwmc_load (.pclk(pclk), .pwm_in(pwm_out), .clr(clr),
    .high_cnt(high_cnt));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done;
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // settle two carrier periods first, then count four of them
  task automatic measure(input int e);
    repeat (32) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (65) @(posedge pclk);
    check("high", e, {16'h0, high_cnt});
  endtask
  task automatic wait_irq;
    int n;
    for (n = 0; n < 64 && irq !== 1'b1; n++) @(posedge pclk);
    check("irq", 1, {31'h0, irq});
    if (irq !== 1'b1) test_done();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_values;
    apb(0, pwmc_pkg::OFF_CTRL, 0);
    check("ctrl", 0, rd);
    apb(0, pwmc_pkg::OFF_DUTY, 0);
    check("duty", 32'h0000ffff, rd);
    apb(0, pwmc_pkg::OFF_COUNT, 0);
    check("count", 0, rd);
    apb(0, 12'h040, 0);
    check("unmapped", 1, {31'h0, err});
  endtask
  // period 3, duty 1: four ticks of four clocks, high for two
  task automatic basic_wave;
    apb(1, pwmc_pkg::OFF_PERIOD, 3);
    apb(1, pwmc_pkg::OFF_DUTY, 1);
    apb(1, pwmc_pkg::OFF_CTRL, 5);
    measure(32);
  endtask
  task automatic full_and_zero;
    apb(1, pwmc_pkg::OFF_IRQ_EN, 1);
    apb(1, pwmc_pkg::OFF_IRQ_CLR, 3);
    wait_irq();
    apb(1, pwmc_pkg::OFF_DUTY, 3);
    measure(64);
    apb(1, pwmc_pkg::OFF_DUTY, 5);
    measure(0);
  endtask
  task automatic late_full;
    apb(1, pwmc_pkg::OFF_IRQ_EN, 2);
    apb(1, pwmc_pkg::OFF_IRQ_CLR, 3);
    wait_irq();
    apb(1, pwmc_pkg::OFF_DUTY, 3);
    measure(0);
    apb(1, pwmc_pkg::OFF_IRQ_EN, 0);
    check("masked", 0, {31'h0, irq});
    apb(0, pwmc_pkg::OFF_IRQ_STAT, 0);
    check("pflag", 1, {31'h0, rd[1]});
  endtask
  task automatic buffered;
    apb(1, pwmc_pkg::OFF_BUFFER, 2);
    apb(1, pwmc_pkg::OFF_DUTY, 1);
    apb(1, pwmc_pkg::OFF_CTRL, 7);
    measure(16);
    apb(0, pwmc_pkg::OFF_DUTY, 0);
    check("dload", 2, rd);
    // by cycle count this write lands on a duty match tick
    apb(1, pwmc_pkg::OFF_BUFFER, 0);
    apb(0, pwmc_pkg::OFF_DUTY, 0);
    check("dcollide", 2, rd);
    apb(0, pwmc_pkg::OFF_BUFFER, 0);
    check("bnew", 0, rd);
    apb(1, pwmc_pkg::OFF_CTRL, 3);
    measure(0);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_values();
    basic_wave();
    full_and_zero();
    late_full();
    buffered();
    test_done();
  end
endmodule // pwmc_top_bench
bind pwmc_top pwmc_checker i_pwmc_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_out(pwm_out), .irq(irq));
